// [mb_write_multi_pkg.sv]
// constants, types and helpers for the multiple-register write handler
package mb_write_multi_pkg;

   // ************************************************************
   // frame byte positions, counted from the first header byte
   // ************************************************************
   localparam logic [8:0]  POS_MSG_END   = 9'h004; // msg number 0..3
   localparam logic [8:0]  POS_STATION   = 9'h006; // station number
   localparam logic [8:0]  POS_FUNC      = 9'h007; // function code
   localparam logic [8:0]  POS_ADDR_HI   = 9'h008; // start address high
   localparam logic [8:0]  POS_ADDR_LO   = 9'h009; // start address low
   localparam logic [8:0]  POS_CNT_HI    = 9'h00A; // word count high
   localparam logic [8:0]  POS_CNT_LO    = 9'h00B; // word count low
   localparam logic [8:0]  POS_BCNT      = 9'h00C; // value byte count
   localparam logic [8:0]  POS_VALUES    = 9'h00D; // first value byte
   localparam logic [8:0]  POS_IDX_MAX   = 9'h1FF; // index saturation

   // ************************************************************
   // codes and limits
   // ************************************************************
   localparam logic [7:0]  STATION_MIN   = 8'h01;
   localparam logic [7:0]  STATION_MAX   = 8'hF7;
   localparam logic [7:0]  FUNC_WRITE    = 8'h10; // write multiple
   localparam logic [7:0]  FUNC_WRITE_ER = 8'h90; // error reply code
   localparam logic [7:0]  EXC_NONE      = 8'h00;
   localparam logic [7:0]  EXC_FUNC      = 8'h01; // illegal function
   localparam logic [7:0]  EXC_ADDR      = 8'h02; // illegal address
   localparam logic [7:0]  EXC_VALUE     = 8'h03; // illegal value
   localparam logic [15:0] WORDS_MAX     = 16'h007B; // 123 words
   localparam logic [7:0]  MEM_WORDS     = 8'h7B;
   localparam int          MEM_DEPTH     = 123;
   localparam logic [16:0] ADDR_SPACE    = 17'h10000;
   localparam logic [15:0] REPLY_LEN_OK  = 16'h0006;
   localparam logic [15:0] REPLY_LEN_ER  = 16'h0003;
   localparam logic [3:0]  TX_LAST_OK    = 4'hB; // 12 byte reply
   localparam logic [3:0]  TX_LAST_ER    = 4'h8; // 9 byte reply

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {ST_RX, ST_WRITE, ST_TX} state_e;

   typedef struct packed {
      logic        valid;
      logic [7:0]  data;
      logic        last;
   } byte_s;

   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
      logic [15:0] data;
   } word_s;

   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
      logic [31:0] data;
   } pair_s;

   typedef struct packed {
      state_e      state;
      logic [8:0]  idx;
      logic [31:0] msg;
      logic        addressed;
      logic [7:0]  station;
      logic [15:0] addr;
      logic [15:0] cnt;
      logic [7:0]  bcnt;
      logic [7:0]  exc;
      logic [7:0]  hi_byte;
      logic [6:0]  wptr;
      logic [3:0]  tidx;
      logic        err;
      logic [7:0]  tx_byte;
      logic        tx_last;
      word_s       wr;
      pair_s       pair;
   } ctrl_s;

   localparam ctrl_s CTRL_RESET = '0;

   // ************************************************************
   // helpers
   // ************************************************************
   // one byte of the reply frame; fields go out high byte first
   function automatic logic [7:0] reply_byte(
      input logic [3:0]  i,
      input logic        err,
      input logic [31:0] msg,
      input logic [7:0]  st,
      input logic [15:0] addr,
      input logic [15:0] cnt,
      input logic [7:0]  exc);
      logic [15:0] len;
      len = err ? REPLY_LEN_ER : REPLY_LEN_OK;
      case (i)
         4'h0:    reply_byte = msg[31:24];
         4'h1:    reply_byte = msg[23:16];
         4'h2:    reply_byte = msg[15:8];
         4'h3:    reply_byte = msg[7:0];
         4'h4:    reply_byte = len[15:8];
         4'h5:    reply_byte = len[7:0];
         4'h6:    reply_byte = st;
         4'h7:    reply_byte = err ? FUNC_WRITE_ER : FUNC_WRITE;
         4'h8:    reply_byte = err ? exc : addr[15:8];
         4'h9:    reply_byte = addr[7:0];
         4'hA:    reply_byte = cnt[15:8];
         4'hB:    reply_byte = cnt[7:0];
         default: reply_byte = 8'h00;
      endcase
   endfunction

   // 32-bit value from two registers sent low word first
   function automatic logic [31:0] join_low_first(
      input logic [15:0] first_word,
      input logic [15:0] second_word);
      join_low_first = {second_word, first_word};
   endfunction

endpackage

// [mb_write_multi.sv]
// frame handler for the write-multiple-holding-register request
`timescale 1ns/1ps

// Behaviour
// - station byte 1..247 and ours, else ignore
// - function 0x10 expected and echoed on success
// - start address taken high byte first
// - word count taken high byte first
// - byte count twice words, values high first
// - success reply echoes station, code, address, count
// - failure reply carries 0x90 and exception code
// - six byte header: message number, remaining length
// - 16-bit contents travel high byte first
// - 32-bit values pair two registers, low first
module modbus_write_multi_regs
   import mb_write_multi_pkg::*;
(
   input  wire logic        clk_sys,     // 200 MHz system clock
   input  wire logic        rst_b,       // async reset, active low
   input  wire logic [7:0]  my_station,  // our station number
   input  wire byte_s       rx,          // request byte stream
   output      logic        rx_ready,    // request byte accepted
   output      byte_s       tx,          // reply byte stream
   input  wire logic        tx_ready,    // reply byte taken
   output      word_s       wr,          // holding register write
   output      pair_s       wr_pair      // 32-bit pair completed
);

   // ************************************************************
   // frame layout and timing
   // ************************************************************
   // request bytes, one per accepted cycle, in wire order:
   //   0..3   message number, copied into the reply
   //   4..5   remaining length, carried but not checked
   //   6      station number, compared with my_station
   //   7      function code, only multiple write served
   //   8..9   first register address, high byte first
   //   10..11 word count, high byte first
   //   12     value byte count, twice the word count
   //   13..   values, two bytes per word, high first
   // the frame is judged when rx.last arrives; the byte index
   // then tells a short or long frame from a good one
   // writes start one edge after the last byte of a good frame,
   // one word per cycle; the reply is loaded on the edge of the
   // final write, so that pulse and the first reply byte share
   // a cycle
   // error frames skip the writes and reply at once
   // foreign or out-of-range stations leave no trace
   // limitation: at most 123 words staged per frame; larger
   // counts are refused before anything is written
   // trade-off: staging costs a small array but keeps a bad
   // frame away from every holding register
   // receive stalls while writes and reply are busy
   // pairs group words by frame index: 0 with 1, 2 with 3
   // reply length is a constant per reply kind, never
   // computed from the request

   // ************************************************************
   // state and value store
   // ************************************************************
   ctrl_s       r_reg;                   // all control state
   ctrl_s       r_next;                  // its next value
   logic [15:0] mem [MEM_DEPTH];         // staged register values
   logic        mem_we;                  // stage one value word
   logic [6:0]  mem_widx;                // word slot to stage
   logic [15:0] mem_wdata;               // word to stage
   logic [8:0]  didx;                    // index into value bytes
   logic [7:0]  exc_v;                   // exception found at end
   logic [15:0] wr_addr_v;               // address of current word

   // rx_ready and tx.valid decode the state, so they move on
   // the same edge as the state and never glitch between bytes
   // handshakes straight from state, data from flops
   assign rx_ready = (r_reg.state == ST_RX);
   assign tx.valid = (r_reg.state == ST_TX);
   assign tx.data  = r_reg.tx_byte;
   assign tx.last  = r_reg.tx_last;
   assign wr       = r_reg.wr;
   assign wr_pair  = r_reg.pair;

   // ************************************************************
   // next state
   // ************************************************************
   // one process computes every next value; the array is
   // written through mem_we, outside the control struct
   // exception codes: 01 bad function, 02 address overrun,
   // 03 bad word count, byte count or value byte total
   // helpers get a value at the top, so no path latches
   // the state struct is copied whole, then fields change
   always_comb
   begin
      r_next     = r_reg;
      r_next.wr.valid   = 1'b0;
      r_next.pair.valid = 1'b0;
      mem_we     = 1'b0;
      mem_widx   = 7'h00;
      mem_wdata  = 16'h0000;
      didx       = r_reg.idx - POS_VALUES;
      exc_v      = r_reg.exc;
      wr_addr_v  = r_reg.addr + {9'h000, r_reg.wptr};
      case (r_reg.state)
         // collect one frame byte per accepted cycle
         ST_RX:
         begin
            if (rx.valid)
            begin
               if (r_reg.idx < POS_MSG_END)
               begin
                  // message number kept in arrival order
                  r_next.msg = {r_reg.msg[23:0], rx.data};
               end
               case (r_reg.idx)
                  POS_STATION:
                  begin
                     r_next.station   = rx.data;
                     // out-of-range or foreign stations never answer
                     r_next.addressed = (rx.data == my_station) &&
                                        (rx.data >= STATION_MIN) &&
                                        (rx.data <= STATION_MAX);
                  end
                  POS_FUNC:
                  begin
                     if (rx.data != FUNC_WRITE)
                     begin
                        // keep draining the frame, answer at its end
                        r_next.exc = EXC_FUNC;
                     end
                  end
                  POS_ADDR_HI: r_next.addr[15:8] = rx.data;
                  POS_ADDR_LO: r_next.addr[7:0]  = rx.data;
                  POS_CNT_HI:  r_next.cnt[15:8]  = rx.data;
                  POS_CNT_LO:  r_next.cnt[7:0]   = rx.data;
                  POS_BCNT:    r_next.bcnt       = rx.data;
                  default:
                  begin
                     // value bytes pair high then low into one word
                     if ((r_reg.idx >= POS_VALUES) &&
                         (didx[8:1] < MEM_WORDS))
                     begin
                        if (!didx[0])
                        begin
                           r_next.hi_byte = rx.data;
                        end
                        else
                        begin
                           mem_we    = 1'b1;
                           mem_widx  = didx[7:1];
                           mem_wdata = {r_reg.hi_byte, rx.data};
                        end
                     end
                  end
               endcase
               // index saturates so an endless frame cannot wrap
               // around and fake a correct byte total
               if (r_reg.idx != POS_IDX_MAX)
               begin
                  r_next.idx = r_reg.idx + 9'h001;
               end
               if (rx.last)
               begin
                  // frame end: judge the whole request at once
                  // a function error on this very byte counts too
                  exc_v = r_next.exc;
                  // order: word count range, address range, then
                  // byte count against words and bytes received
                  if (exc_v == EXC_NONE)
                  begin
                     if ((r_next.cnt == 16'h0000) ||
                         (r_next.cnt > WORDS_MAX))
                     begin
                        exc_v = EXC_VALUE;
                     end
                     else if (({1'b0, r_next.addr} +
                               {1'b0, r_next.cnt}) > ADDR_SPACE)
                     begin
                        exc_v = EXC_ADDR;
                     end
                     else if ((r_next.bcnt != {r_next.cnt[6:0], 1'b0}) ||
                              (r_reg.idx + 9'h001 !=
                               POS_VALUES + {1'b0, r_next.bcnt}))
                     begin
                        // staged words are simply dropped here
                        exc_v = EXC_VALUE;
                     end
                  end
                  r_next.idx  = 9'h000;
                  r_next.exc  = exc_v;
                  r_next.err  = (exc_v != EXC_NONE);
                  r_next.tidx = 4'h0;
                  r_next.wptr = 7'h00;
                  if (!r_next.addressed)
                  begin
                     // not for us: stay silent, start over
                     r_next.exc       = EXC_NONE;
                     r_next.addressed = 1'b0;
                  end
                  else if (exc_v != EXC_NONE)
                  begin
                     r_next.state   = ST_TX;
                     r_next.tx_byte = reply_byte(4'h0, 1'b1,
                        r_next.msg, r_next.station, r_next.addr,
                        r_next.cnt, exc_v);
                     r_next.tx_last = 1'b0;
                  end
                  else
                  begin
                     r_next.state = ST_WRITE;
                  end
               end
            end
         end
         // word k goes to start address plus k; every odd word
         // closes a 32-bit pair whose low word is the one before
         // commit staged words, one per cycle, only after checks
         ST_WRITE:
         begin
            r_next.wr.valid = 1'b1;
            r_next.wr.addr  = wr_addr_v;
            r_next.wr.data  = mem[r_reg.wptr];
            if (r_reg.wptr[0])
            begin
               // odd slot closes a pair begun by the word before it
               r_next.pair.valid = 1'b1;
               r_next.pair.addr  = wr_addr_v - 16'h0001;
               r_next.pair.data  = join_low_first(
                  mem[r_reg.wptr - 7'h01], mem[r_reg.wptr]);
            end
            r_next.wptr = r_reg.wptr + 7'h01;
            if ({9'h000, r_reg.wptr} + 16'h0001 == r_reg.cnt)
            begin
               r_next.state   = ST_TX;
               r_next.tx_byte = reply_byte(4'h0, 1'b0, r_reg.msg,
                  r_reg.station, r_reg.addr, r_reg.cnt,
                  r_reg.exc);
               r_next.tx_last = 1'b0;
            end
         end
         // host may stall for any number of cycles
         // send the reply, holding each byte until taken
         ST_TX:
         begin
            if (tx_ready)
            begin
               if (r_reg.tx_last)
               begin
                  // final byte taken: clear frame state and
                  // listen again from the next cycle on
                  r_next.state     = ST_RX;
                  r_next.exc       = EXC_NONE;
                  r_next.addressed = 1'b0;
                  r_next.err       = 1'b0;
               end
               else
               begin
                  r_next.tidx    = r_reg.tidx + 4'h1;
                  r_next.tx_byte = reply_byte(r_reg.tidx + 4'h1,
                     r_reg.err, r_reg.msg, r_reg.station, r_reg.addr,
                     r_reg.cnt, r_reg.exc);
                  r_next.tx_last = (r_reg.tidx + 4'h1) ==
                     (r_reg.err ? TX_LAST_ER : TX_LAST_OK);
               end
            end
         end
         default:
         begin
            // unreachable state: fall back to a clean idle
            r_next = CTRL_RESET;
         end
      endcase
   end

   // ************************************************************
   // registers
   // ************************************************************
   // reset clears only the control struct; the value array is
   // always rewritten by a frame before it is read back
   // control state, cleared by reset
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         r_reg <= CTRL_RESET;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   // one word per cycle at most, so a single write port does
   // value store needs no reset: read only after a full frame
   always_ff @(posedge clk_sys)
   begin
      if (mem_we)
      begin
         mem[mem_widx] <= mem_wdata;
      end
   end

endmodule

// [mb_write_multi_asserts.sv]
// port checks for the write-multiple handler
`timescale 1ns/1ps
module mb_write_multi_asserts
   import mb_write_multi_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       rst_b,
   input wire logic [7:0] my_station,
   input wire byte_s      rx,
   input wire logic       rx_ready,
   input wire byte_s      tx,
   input wire logic       tx_ready,
   input wire word_s      wr,
   input wire pair_s      wr_pair
);
   // ************************************************************
   // helper: position of the reply byte on offer
   // ************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   logic [3:0] pos_reg; // counts taken reply bytes
   logic       take;    // reply byte leaves this edge
   assign take = tx.valid && tx_ready;
   // restart at each final byte, so a lost last shows as a bad slot
   always_ff @(posedge clk_sys or negedge rst_b)
      if (!rst_b)
         pos_reg <= 4'h0;
      else if (take)
         pos_reg <= tx.last ? 4'h0 : pos_reg + 4'h1;
   sequence s_take_last;
      tx.valid && tx_ready && tx.last;
   endsequence
   sequence s_back_to_rx;
      rx_ready && !tx.valid;
   endsequence
   // ************************************************************
   // assertions
   // ************************************************************
   a_station_echo: assert property (take && pos_reg == 4'h6 |->
      tx.data == my_station) else $error("reply station wrong");
   a_func_echo: assert property (take && pos_reg == 4'h7 |->
      tx.data == FUNC_WRITE || tx.data == FUNC_WRITE_ER)
      else $error("reply function code wrong");
   a_len_high: assert property (take && pos_reg == 4'h4 |->
      tx.data == 8'h00) else $error("reply length high wrong");
   a_len_low: assert property (take && pos_reg == 4'h5 |->
      tx.data == 8'h06 || tx.data == 8'h03)
      else $error("reply length low wrong");
   a_last_slot: assert property (s_take_last |->
      pos_reg == 4'hB || pos_reg == 4'h8) else $error("reply size wrong");
   a_ready_back: assert property (s_take_last |=> s_back_to_rx)
      else $error("receive not resumed after reply");
   a_tx_hold: assert property (tx.valid && !tx_ready |=>
      tx.valid && $stable(tx.data) && $stable(tx.last))
      else $error("reply byte changed before taken");
   a_wr_quiet: assert property (wr.valid |->
      !rx_ready && !$past(tx.valid))
      else $error("write outside write phase");
   a_wr_step: assert property (wr.valid && $past(wr.valid) |->
      wr.addr == $past(wr.addr) + 16'h0001)
      else $error("write address not ascending");
   a_pair_join: assert property (wr_pair.valid |-> wr.valid &&
      wr_pair.addr == $past(wr.addr) &&
      wr_pair.data == {wr.data, $past(wr.data)})
      else $error("pair value wrong");
endmodule

bind modbus_write_multi_regs mb_write_multi_asserts chk_u (
   .clk_sys    (clk_sys),
   .rst_b      (rst_b),
   .my_station (my_station),
   .rx         (rx),
   .rx_ready   (rx_ready),
   .tx         (tx),
   .tx_ready   (tx_ready),
   .wr         (wr),
   .wr_pair    (wr_pair)
);

// [mb_host_model.sv]
// remote host model: takes reply bytes promptly or with stalls
`timescale 1ns/1ps
module mb_host_model
   import mb_write_multi_pkg::*;
(
   input  wire logic  clk_sys,  // system clock
   input  wire logic  rst_b,    // async reset, active low
   input  wire logic  slow,     // stall at random when high
   input  wire byte_s tx,       // reply stream from the device
   output      logic  tx_ready, // host takes a byte
   output      byte_s got       // byte taken, settled by next rise
);
   // ready changes only after a rising edge
   always @(posedge clk_sys or negedge rst_b)
      if (!rst_b)
         tx_ready <= 1'b0;
      else
         tx_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
   // bytes kept in wire order, high byte of each field first
   always @(negedge clk_sys)
      got <= (tx.valid && tx_ready) ? tx : '0;
endmodule

// [modbus_write_multi_regs_bench.sv]
// self-checking bench for the write-multiple handler
`timescale 1ns/1ps
module modbus_write_multi_regs_bench;
   import mb_write_multi_pkg::*;
   logic        clk_sys;     // 200 MHz
   logic        rst_b;       // active low reset
   logic [7:0]  my_station;  // our station
   byte_s       rx;          // request stream
   logic        rx_ready;    // request byte taken
   byte_s       tx;          // reply stream
   logic        tx_ready;    // from host model
   word_s       wr;          // register writes
   pair_s       wr_pair;     // 32-bit pairs
   byte_s       got;         // reply byte seen by host
   logic        slow;        // host stalls
   int          mismatches;  // failed comparisons
   int          compares;    // all comparisons
   int          cyc;         // cycle count for the hang guard
   logic [7:0]  rq[$];       // reply bytes received
   logic [7:0]  ex_tx[$];    // reply expected
   logic [47:0] ex_wr[$];    // writes expected {addr, data}
   logic [47:0] ex_pair[$];  // pairs expected {addr, data}

   modbus_write_multi_regs dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
      .my_station(my_station), .rx(rx), .rx_ready(rx_ready), .tx(tx),
      .tx_ready(tx_ready), .wr(wr), .wr_pair(wr_pair));
   mb_host_model host_u (.clk_sys(clk_sys), .rst_b(rst_b), .slow(slow),
      .tx(tx), .tx_ready(tx_ready), .got(got));

   // ************************************************************
   // reporting
   // ************************************************************
   task automatic check(input string name, input logic [47:0] seen,
                        input logic [47:0] exp);
      compares++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ************************************************************
   // clock, hang guard and monitors
   // ************************************************************
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // the whole run needs well under 20000 cycles
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         mismatches++;
         test_done();
      end
   end
   // writes are one-cycle pulses, looked at mid-cycle
   always @(negedge clk_sys)
   begin
      if (rst_b === 1'b1 && wr.valid === 1'b1)
         check("write", {wr.addr, 16'h0000, wr.data}, ex_wr.size() ?
            ex_wr.pop_front() : 'x);
      if (rst_b === 1'b1 && wr_pair.valid === 1'b1)
         check("pair", {wr_pair.addr, wr_pair.data}, ex_pair.size() ?
            ex_pair.pop_front() : 'x);
   end
   always @(posedge clk_sys)
      if (got.valid === 1'b1)
         rq.push_back(got.data);

   // ************************************************************
   // one request frame and its expected outcome
   // ************************************************************
   task automatic put(input logic [7:0] d, input logic l);
      rx <= '{valid: 1'b1, data: d, last: l};
      do @(negedge clk_sys); while (rx_ready !== 1'b1);
      @(posedge clk_sys);
   endtask
   task automatic run(input logic [7:0] st, input logic [7:0] fn,
      input logic [15:0] ad, input logic [15:0] cn, input logic [7:0] bc,
      input int nv);
      logic [31:0] msg;
      logic [7:0]  fr[$];
      logic [7:0]  exc;
      logic [15:0] len;
      bit          ans;
      int          k;
      @(posedge clk_sys); // let a new my_station settle first
      msg = $urandom;
      len = 16'(7 + nv);
      fr = {msg[31:24], msg[23:16], msg[15:8], msg[7:0], len[15:8],
            len[7:0], st, fn, ad[15:8], ad[7:0], cn[15:8], cn[7:0], bc};
      for (k = 0; k < nv; k++)
         fr.push_back(8'($urandom));
      ans = st >= 8'h01 && st <= 8'hF7 && st == my_station;
      if (fn != 8'h10)
         exc = 8'h01;
      else if (cn == 0 || cn > 123)
         exc = 8'h03;
      else if (32'(ad) + 32'(cn) > 32'h10000)
         exc = 8'h02;
      else if (bc != 2 * cn || nv != bc)
         exc = 8'h03;
      else
         exc = 8'h00;
      if (ans)
      begin
         ex_tx = {msg[31:24], msg[23:16], msg[15:8], msg[7:0], 8'h00,
            exc ? 8'h03 : 8'h06, st, exc ? 8'h90 : 8'h10};
         if (exc)
            ex_tx.push_back(exc);
         else
            ex_tx = {ex_tx, ad[15:8], ad[7:0], cn[15:8], cn[7:0]};
      end
      for (k = 0; ans && exc == 0 && k < cn; k++)
      begin
         ex_wr.push_back({ad + 16'(k), 16'h0000, fr[13+2*k], fr[14+2*k]});
         if (k % 2)
            ex_pair.push_back({ad + 16'(k - 1), fr[13+2*k], fr[14+2*k],
               fr[11+2*k], fr[12+2*k]});
      end
      foreach (fr[i])
         put(fr[i], i == fr.size() - 1);
      rx <= '0;
      repeat (30) @(posedge clk_sys);
      for (k = 0; k < 600 && (rq.size() < ex_tx.size()
           || rx_ready !== 1'b1); k++)
         @(posedge clk_sys);
      check("reply size", rq.size(), ex_tx.size());
      foreach (ex_tx[i])
         check("reply byte", rq[i], ex_tx[i]);
      check("writes left", ex_wr.size() + ex_pair.size(), 0);
      rq.delete();
      ex_tx.delete();
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      rst_b = 1'b0;
      rx = '0;
      my_station = 8'h11;
      slow = 1'b0;
      void'($urandom(32'h58f7c932));
      repeat (20) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      run(8'h11, 8'h10, 16'h0032, 16'h0001, 8'h02, 2);
      slow <= 1'b1;
      run(8'h11, 8'h10, 16'($urandom_range(0, 999)), 16'h0004, 8'h08, 8);
      run(8'h11, 8'h10, 16'h0100, 16'h007B, 8'hF6, 246);
      run(8'h12, 8'h10, 16'h0000, 16'h0001, 8'h02, 2);
      my_station <= 8'h00;
      run(8'h00, 8'h10, 16'h0000, 16'h0001, 8'h02, 2);
      my_station <= 8'hF8;
      run(8'hF8, 8'h10, 16'h0000, 16'h0001, 8'h02, 2);
      my_station <= 8'hF7;
      run(8'hF7, 8'h10, 16'hFFFE, 16'h0002, 8'h04, 4);
      slow <= 1'b0;
      run(8'hF7, 8'h03, 16'h0000, 16'h0001, 8'h02, 2);
      run(8'hF7, 8'h10, 16'hFFFF, 16'h0002, 8'h04, 4);
      run(8'hF7, 8'h10, 16'hFFFF, 16'h0002, 8'h03, 3);
      run(8'hF7, 8'h10, 16'h0000, 16'h0000, 8'h00, 0);
      run(8'hF7, 8'h10, 16'h0000, 16'h007C, 8'hF8, 248);
      run(8'hF7, 8'h10, 16'h0000, 16'h0002, 8'h03, 3);
      run(8'hF7, 8'h10, 16'h0000, 16'h0003, 8'h06, 4);
      test_done();
   end
endmodule
